// [pkg/cabc_pkg.sv]
// constants, opcode groups and states of the 8-bit core
// Operation
// - add, and, subtract use the accumulator as operand and destination; compare only reads it
// - second operand is indirect, direct data space, or immediate
// - zero, decrement, increment accept any of 256 data-space addresses
// - invert, rotate through carry, shift left act on accumulator only
// - immediates come from program bytes after the opcode
// - conditional branches jump only when their condition holds
// - short relative branches span -15 to +16 from the branch
// - bit-test branches span -126 to +129 with 8-bit signed displacement
// - branch on bit reset jumps when bit is 0; 3 bytes, 5 cycles
// - branch on bit set jumps when bit is 1; same size and timing
// - bit-test branch copies tested bit into carry, zero unchanged
// - bit set and clear reach any bit, flags unchanged
// - bit set forces one, bit clear forces zero; tests are a separate group
// - bit position is a 3-bit opcode field
// - with watchdog selected, stop behaves as wait
// - long jump and call carry 12-bit targets over all program space
// - target is high opcode nibble above the next byte
// - return addresses live in a stack of six 12-bit cells
// - relative opcode has direction bit, 0 forward, and 4-bit span
package cabc_pkg;
    localparam int unsigned STACK_DEPTH = 6;
    localparam logic [2:0]  SP_FULL     = 3'h6;
    localparam logic [1:0]  MC_LAST     = 2'h3;
    localparam logic [2:0]  CYC_SHORT   = 3'h2;
    localparam logic [2:0]  CYC_STD     = 3'h4;
    localparam logic [2:0]  CYC_BT      = 3'h5;
    localparam logic [11:0] RESET_PC    = 12'h000;
    localparam logic [11:0] PC_STEP     = 12'h001;
    localparam logic [11:0] BT_BASE     = 12'h002;
    localparam logic [7:0]  ADDR_X      = 8'h80;
    localparam logic [7:0]  ADDR_Y      = 8'h81;
    localparam logic [7:0]  ADDR_ACC    = 8'hFF;
    localparam logic [7:0]  BIT_ONE     = 8'h01;
    localparam logic [3:0]  LO_CALL     = 4'h1;
    localparam logic [3:0]  LO_BTST     = 4'h3;
    localparam logic [3:0]  LO_INH      = 4'h5;
    localparam logic [3:0]  LO_ALU_IND  = 4'h7;
    localparam logic [3:0]  LO_JUMP     = 4'h9;
    localparam logic [3:0]  LO_BSR      = 4'hB;
    localparam logic [3:0]  LO_UNARY    = 4'hD;
    localparam logic [3:0]  LO_ALU_DIR  = 4'hF;
    localparam logic [1:0]  ALU_ADD     = 2'h0;
    localparam logic [1:0]  ALU_AND     = 2'h1;
    localparam logic [1:0]  ALU_CMP     = 2'h2;
    localparam logic [1:0]  ALU_SUB     = 2'h3;
    localparam logic [1:0]  UN_CLR      = 2'h0;
    localparam logic [1:0]  UN_INC      = 2'h1;
    localparam logic [1:0]  UN_DEC      = 2'h2;
    localparam logic [3:0]  INH_RET     = 4'h1;
    localparam logic [3:0]  INH_RETURN_FROM_INTERRUPT    = 4'h2;
    localparam logic [3:0]  INH_STOP    = 4'h3;
    localparam logic [3:0]  INH_WAIT    = 4'h4;
    localparam logic [3:0]  INH_COM     = 4'h5;
    localparam logic [3:0]  INH_RLC     = 4'h6;
    localparam logic [3:0]  INH_SLA     = 4'h7;
    localparam logic [1:0]  COND_NZ     = 2'h0;
    localparam logic [1:0]  COND_NC     = 2'h1;
    localparam logic [1:0]  COND_Z      = 2'h2;
    localparam logic [1:0]  COND_C      = 2'h3;
    typedef enum logic [7:0] {
        S_FETCH   = 8'h01,
        S_BYTE2   = 8'h02,
        S_BYTE3   = 8'h04,
        S_PTR     = 8'h08,
        S_MEMRD   = 8'h10,
        S_EXEC    = 8'h20,
        S_WAITEND = 8'h40,
        S_HALT    = 8'h80
    } cabc_state_t;
endpackage

// [rtl/cabc_stack.sv]
// six-cell return address stack with registered top of stack
`timescale 1ns/100ps
`default_nettype none
module cabc_stack (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [11:0] push_addr,
    output logic      [11:0] top_q,
    output logic             overflow_q
);
    logic [11:0] cell_q [cabc_pkg::STACK_DEPTH];
    logic [2:0]  sp_q;
    wire         full  = (sp_q == cabc_pkg::SP_FULL);
    wire  [2:0]  below = sp_q - 3'h2;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sp_q       <= 3'h0;
            top_q      <= 12'h000;
            overflow_q <= 1'b0;
        end else if (push) begin
            if (full) begin
                overflow_q <= 1'b1;
            end else begin
                cell_q[sp_q] <= push_addr;
                sp_q         <= sp_q + 3'h1;
                top_q        <= push_addr;
            end
        end else if (pop && sp_q != 3'h0) begin
            sp_q  <= sp_q - 3'h1;
            top_q <= (sp_q > 3'h1) ? cell_q[below] : 12'h000;
        end
    end
endmodule
`default_nettype wire

// [rtl/cabc_core.sv]
// multi-cycle 8-bit core: fetch, decode, alu, branches, bit ops, control
`timescale 1ns/100ps
`default_nettype none
module cabc_core (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    output logic      [11:0] prog_addr,
    input  wire logic [7:0]  prog_rdata,
    output logic      [7:0]  data_addr,
    output logic      [7:0]  data_wdata,
    output logic             data_we,
    input  wire logic [7:0]  data_rdata,
    input  wire logic        irq_req,
    input  wire logic [11:0] irq_vector,
    output logic             irq_ack,
    input  wire logic        wdg_sel,
    output logic             core_stopped,
    output logic             core_waiting,
    output logic             stack_overflow
);
    cabc_pkg::cabc_state_t st_q;
    logic [11:0] pc_q, ipc_q, prog_addr_q;
    logic [7:0]  op_q, b2_q, b3_q, mem_q, acc_q;
    logic [7:0]  data_addr_q, data_wdata_q;
    logic        data_we_q, z_q, c_q, sz_q, sc_q, in_irq_q;
    logic        stop_q, wait_q, irq_ack_q;
    logic [1:0]  div_q;
    logic [2:0]  mcyc_q;
    logic [11:0] stk_top;

    function automatic logic [8:0] alu_f(input logic [1:0] sel,
                                         input logic [7:0] a,
                                         input logic [7:0] b);
        logic [8:0] r;
        r = 9'h000;
        case (sel)
            cabc_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, b};
            cabc_pkg::ALU_AND: r = {1'b0, a & b};
            default:           r = {1'b0, a} - {1'b0, b};
        endcase
        return r;
    endfunction

    function automatic logic f_b2(input logic [7:0] o);
        return o[0] && o[3:0] != cabc_pkg::LO_INH && o[3:0] != cabc_pkg::LO_ALU_IND;
    endfunction

    function automatic logic f_mem(input logic [7:0] o);
        return o[3:0] == cabc_pkg::LO_BSR || o[3:0] == cabc_pkg::LO_UNARY
            || (o[3:0] == cabc_pkg::LO_ALU_DIR && !o[4]);
    endfunction

    // opcode groups
    wire [3:0] lo       = op_q[3:0];
    wire       is_rel   = !op_q[0];
    wire       is_call  = (lo == cabc_pkg::LO_CALL);
    wire       is_jp    = (lo == cabc_pkg::LO_JUMP);
    wire       is_bt    = (lo == cabc_pkg::LO_BTST);
    wire       is_bsr   = (lo == cabc_pkg::LO_BSR);
    wire       is_inh   = (lo == cabc_pkg::LO_INH);
    wire       is_un    = (lo == cabc_pkg::LO_UNARY);
    wire       is_alu   = (lo == cabc_pkg::LO_ALU_IND) || (lo == cabc_pkg::LO_ALU_DIR);
    wire       is_imm   = (lo == cabc_pkg::LO_ALU_DIR) && op_q[4];
    wire [1:0] alu_sel  = op_q[6:5];
    wire [3:0] inh_op   = op_q[7:4];
    wire [2:0] bit_pos  = op_q[7:5];
    wire       in_stop  = is_inh && inh_op == cabc_pkg::INH_STOP;
    wire       in_wait  = is_inh && inh_op == cabc_pkg::INH_WAIT;
    wire       in_ret   = is_inh && inh_op == cabc_pkg::INH_RET;
    wire       in_return_from_interrupt  = is_inh && inh_op == cabc_pkg::INH_RETURN_FROM_INTERRUPT;

    // alu datapath
    wire [7:0] alu_b    = is_imm ? b2_q : mem_q;
    wire [8:0] alu_r    = alu_f(alu_sel, acc_q, alu_b);
    wire       alu_wr   = is_alu && alu_sel != cabc_pkg::ALU_CMP;
    wire [1:0] un_op    = op_q[6:5];
    wire [1:0] un_sel   = (un_op == cabc_pkg::UN_INC) ? cabc_pkg::ALU_ADD : cabc_pkg::ALU_SUB;
    wire [8:0] un_r     = alu_f(un_sel, mem_q, cabc_pkg::BIT_ONE);
    wire       un_clr   = (un_op == cabc_pkg::UN_CLR);
    wire [7:0] un_val   = un_clr ? 8'h00 : un_r[7:0];
    wire [7:0] bit_mask = cabc_pkg::BIT_ONE << bit_pos;
    wire [7:0] bsr_val  = op_q[4] ? (mem_q | bit_mask)
                                  : (mem_q & ~bit_mask);
    wire       test_bit = mem_q[bit_pos];
    wire [7:0] com_val  = ~acc_q;
    wire [7:0] rlc_val  = {acc_q[6:0], c_q};
    wire [7:0] sla_val  = {acc_q[6:0], 1'b0};

    // branch targets
    wire [11:0] span    = {8'h00, op_q[7:4]};
    wire [11:0] rel_tgt = op_q[3] ? (ipc_q - span)
                                  : (ipc_q + cabc_pkg::PC_STEP + span);
    wire [11:0] bt_tgt  = ipc_q + cabc_pkg::BT_BASE + {{4{b3_q[7]}}, b3_q};
    wire [11:0] ext_tgt = {op_q[7:4], b2_q};
    logic       cond_ok;
    always_comb begin
        case (op_q[2:1])
            cabc_pkg::COND_NZ: cond_ok = !z_q;
            cabc_pkg::COND_NC: cond_ok = !c_q;
            cabc_pkg::COND_Z:  cond_ok = z_q;
            default:           cond_ok = c_q;
        endcase
    end
    wire bt_take = (test_bit == op_q[4]);

    // instruction length in machine cycles
    wire [2:0] cyc_tgt  = (is_rel || is_inh) ? cabc_pkg::CYC_SHORT
                        : is_bt ? cabc_pkg::CYC_BT : cabc_pkg::CYC_STD;
    wire       mc_tick  = (div_q == cabc_pkg::MC_LAST);
    wire       ins_end  = (st_q == cabc_pkg::S_WAITEND) && mc_tick && (mcyc_q == cyc_tgt - 3'h1);
    wire       exec     = (st_q == cabc_pkg::S_EXEC);
    wire       halt_go  = exec && (in_wait || in_stop);
    wire       leave_ok = ins_end || ((st_q == cabc_pkg::S_HALT) && irq_req);
    wire       irq_take = leave_ok && irq_req && !in_irq_q && !(ins_end && (stop_q || wait_q));
    wire       push     = (exec && is_call) || irq_take;
    wire       pop      = exec && (in_ret || in_return_from_interrupt);
    wire [7:0] mem_in   = (data_addr_q == cabc_pkg::ADDR_ACC) ? acc_q : data_rdata;
    wire       wb_en    = is_un || is_bsr;
    wire [7:0] wb_val   = is_un ? un_val : bsr_val;
    wire       wb_acc   = (data_addr_q == cabc_pkg::ADDR_ACC);

    cabc_stack u_stack (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .push       (push),
        .pop        (pop),
        .push_addr  (pc_q),
        .top_q      (stk_top),
        .overflow_q (stack_overflow)
    );

    // machine cycle divider
    always_ff @(posedge sys_clk) begin
        if (sys_rst || ins_end || st_q == cabc_pkg::S_HALT) begin // fetch opens cycle 0
            div_q  <= 2'h0;
            mcyc_q <= 3'h0;
        end else if (mc_tick) begin
            div_q  <= 2'h0;
            mcyc_q <= mcyc_q + 3'h1;
        end else begin
            div_q  <= div_q + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q         <= cabc_pkg::S_FETCH;
            pc_q         <= cabc_pkg::RESET_PC;
            ipc_q        <= cabc_pkg::RESET_PC;
            prog_addr_q  <= cabc_pkg::RESET_PC;
            op_q         <= 8'h00;
            b2_q         <= 8'h00;
            b3_q         <= 8'h00;
            mem_q        <= 8'h00;
            acc_q        <= 8'h00;
            data_addr_q  <= 8'h00;
            data_wdata_q <= 8'h00;
            data_we_q    <= 1'b0;
            z_q          <= 1'b0;
            c_q          <= 1'b0;
            sz_q         <= 1'b0;
            sc_q         <= 1'b0;
            in_irq_q     <= 1'b0;
            stop_q       <= 1'b0;
            wait_q       <= 1'b0;
            irq_ack_q    <= 1'b0;
        end else begin
            irq_ack_q <= 1'b0;
            data_we_q <= 1'b0;
            case (st_q)
                cabc_pkg::S_FETCH: begin
                    op_q        <= prog_rdata;
                    ipc_q       <= pc_q;
                    pc_q        <= pc_q + cabc_pkg::PC_STEP;
                    prog_addr_q <= pc_q + cabc_pkg::PC_STEP;
                    if (!prog_rdata[0]) begin
                        st_q <= cabc_pkg::S_EXEC;
                    end else if (f_b2(prog_rdata)) begin
                        st_q <= cabc_pkg::S_BYTE2;
                    end else if (prog_rdata[3:0] == cabc_pkg::LO_ALU_IND) begin
                        data_addr_q <= prog_rdata[4] ? cabc_pkg::ADDR_Y : cabc_pkg::ADDR_X;
                        st_q        <= cabc_pkg::S_PTR;
                    end else begin
                        st_q <= cabc_pkg::S_EXEC;
                    end
                end
                cabc_pkg::S_BYTE2: begin
                    b2_q        <= prog_rdata;
                    pc_q        <= pc_q + cabc_pkg::PC_STEP;
                    prog_addr_q <= pc_q + cabc_pkg::PC_STEP;
                    data_addr_q <= prog_rdata;
                    if (is_bt) begin
                        st_q <= cabc_pkg::S_BYTE3;
                    end else if (f_mem(op_q)) begin
                        st_q <= cabc_pkg::S_MEMRD;
                    end else begin
                        st_q <= cabc_pkg::S_EXEC;
                    end
                end
                cabc_pkg::S_BYTE3: begin
                    b3_q        <= prog_rdata;
                    pc_q        <= pc_q + cabc_pkg::PC_STEP;
                    prog_addr_q <= pc_q + cabc_pkg::PC_STEP;
                    st_q        <= cabc_pkg::S_MEMRD;
                end
                cabc_pkg::S_PTR: begin
                    data_addr_q <= data_rdata;
                    st_q        <= cabc_pkg::S_MEMRD;
                end
                cabc_pkg::S_MEMRD: begin
                    mem_q <= mem_in;
                    st_q  <= cabc_pkg::S_EXEC;
                end
                cabc_pkg::S_EXEC: begin
                    st_q <= cabc_pkg::S_WAITEND;
                    if (is_alu) begin
                        z_q <= (alu_r[7:0] == 8'h00);
                        c_q <= alu_r[8];
                        if (alu_wr) begin
                            acc_q <= alu_r[7:0];
                        end
                    end else if (wb_en) begin
                        if (is_un && !un_clr) begin
                            z_q <= (un_r[7:0] == 8'h00);
                        end
                        if (wb_acc) begin
                            acc_q <= wb_val;
                        end else begin
                            data_wdata_q <= wb_val;
                            data_we_q    <= 1'b1;
                        end
                    end else if (is_bt) begin
                        c_q <= test_bit;
                        if (bt_take) begin
                            pc_q        <= bt_tgt;
                            prog_addr_q <= bt_tgt;
                        end
                    end else if (is_rel) begin
                        if (cond_ok) begin
                            pc_q        <= rel_tgt;
                            prog_addr_q <= rel_tgt;
                        end
                    end else if (is_call || is_jp) begin
                        pc_q        <= ext_tgt;
                        prog_addr_q <= ext_tgt;
                    end else if (is_inh) begin
                        case (inh_op)
                            cabc_pkg::INH_RET: begin
                                pc_q        <= stk_top;
                                prog_addr_q <= stk_top;
                            end
                            cabc_pkg::INH_RETURN_FROM_INTERRUPT: begin
                                pc_q        <= stk_top;
                                prog_addr_q <= stk_top;
                                z_q         <= sz_q;
                                c_q         <= sc_q;
                                in_irq_q    <= 1'b0;
                            end
                            cabc_pkg::INH_COM: begin
                                acc_q <= com_val;
                                z_q   <= (com_val == 8'h00);
                                c_q   <= com_val[7];
                            end
                            cabc_pkg::INH_RLC: begin
                                acc_q <= rlc_val;
                                z_q   <= (rlc_val == 8'h00);
                                c_q   <= acc_q[7];
                            end
                            cabc_pkg::INH_SLA: begin
                                acc_q <= sla_val;
                                z_q   <= (sla_val == 8'h00);
                                c_q   <= acc_q[7];
                            end
                            default: begin
                            end
                        endcase
                    end
                    if (halt_go) begin
                        stop_q <= in_stop && !wdg_sel;
                        wait_q <= in_wait || wdg_sel;
                    end
                end
                default: begin
                    // end of instruction or halted: take interrupt or fetch
                    if (leave_ok && !(ins_end && (stop_q || wait_q))) begin
                        stop_q <= 1'b0;
                        wait_q <= 1'b0;
                        st_q   <= cabc_pkg::S_FETCH;
                        if (irq_take) begin
                            sz_q        <= z_q;
                            sc_q        <= c_q;
                            in_irq_q    <= 1'b1;
                            irq_ack_q   <= 1'b1;
                            pc_q        <= irq_vector;
                            prog_addr_q <= irq_vector;
                        end
                    end else if (ins_end) begin
                        st_q <= cabc_pkg::S_HALT;
                    end
                end
            endcase
        end
    end

    assign prog_addr    = prog_addr_q;
    assign data_addr    = data_addr_q;
    assign data_wdata   = data_wdata_q;
    assign data_we      = data_we_q;
    assign irq_ack      = irq_ack_q;
    assign core_stopped = stop_q && st_q == cabc_pkg::S_HALT;
    assign core_waiting = wait_q && st_q == cabc_pkg::S_HALT;

    property p_acc_dest;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && alu_wr) |=> (acc_q == $past(alu_r[7:0]));
    endproperty
    a_acc_dest: assert property (p_acc_dest) else $error("alu result not in acc");

    property p_rel_not_taken;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && is_rel && !cond_ok) |=> (pc_q == $past(ipc_q) + cabc_pkg::PC_STEP);
    endproperty
    a_rel_not_taken: assert property (p_rel_not_taken) else $error("branch taken wrongly");

    property p_rel_taken;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && is_rel && cond_ok) |=> (prog_addr == $past(rel_tgt)) && (pc_q == $past(rel_tgt));
    endproperty
    a_rel_taken: assert property (p_rel_taken) else $error("relative target wrong");

    property p_bt_carry;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && is_bt) |=> (c_q == $past(test_bit)) && $stable(z_q);
    endproperty
    a_bt_carry: assert property (p_bt_carry) else $error("tested bit not in carry");

    property p_bt_len;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && is_bt && !irq_req) |-> ##15 ins_end ##1 (st_q == cabc_pkg::S_FETCH)
            && (mcyc_q == 3'h0);
    endproperty
    a_bt_len: assert property (p_bt_len) else $error("bit test length wrong");

    property p_bsr_flags;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && is_bsr && !wb_acc) |=> $stable(z_q) && $stable(c_q) && data_we
            && (data_wdata == $past(bsr_val));
    endproperty
    a_bsr_flags: assert property (p_bsr_flags) else $error("bit set/clear wrong");

    property p_stop_wdg;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && in_stop && wdg_sel) |=> !stop_q && wait_q;
    endproperty
    a_stop_wdg: assert property (p_stop_wdg) else $error("stop not replaced by wait");

    property p_ext_target;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && (is_jp || is_call)) |=> (pc_q == {$past(op_q[7:4]), $past(b2_q)});
    endproperty
    a_ext_target: assert property (p_ext_target) else $error("long target wrong");

    property p_return_from_interrupt_flags;
        @(posedge sys_clk) disable iff (sys_rst)
        (exec && in_return_from_interrupt) |=> (z_q == $past(sz_q)) && (c_q == $past(sc_q));
    endproperty
    a_return_from_interrupt_flags: assert property (p_return_from_interrupt_flags) else $error("flags not restored");
endmodule
`default_nettype wire

// [sim/tb_cabc_core.sv]
// self-checking bench for the 8-bit core: branches, bit ops, alu, halt modes
`timescale 1ns/100ps
`default_nettype none
module tb_cabc_core;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wdg_sel = 1'b0;
    logic [7:0]  prog_rdata = 8'h00;
    logic [7:0]  data_rdata = 8'h00;
    logic [11:0] prog_addr;
    logic [7:0]  data_addr;
    logic [7:0]  data_wdata;
    logic        data_we;
    logic        core_stopped;
    logic        core_waiting;
    logic        irq_req = 1'b0;
    logic [11:0] irq_vector = 12'h000;
    logic        irq_ack;
    logic        stack_overflow;
    logic [7:0]  rom [0:4095];
    logic [7:0]  ram [0:255];
    logic [7:0]  code [0:34] = '{8'h0D, 8'hFF, 8'h1F, 8'h05, 8'h7F, 8'h05, 8'h24, 8'h1B,
        8'h20, 8'h1B, 8'h21, 8'h13, 8'h21, 8'h03, 8'h3B, 8'h20, 8'h26, 8'h5B, 8'h20, 8'h32,
        8'h0B, 8'h21, 8'hFB, 8'h21, 8'h5F, 8'h05, 8'h63, 8'hFF, 8'h03, 8'h7B, 8'h20, 8'h12,
        8'h35, 8'h29, 8'h36};
    int          fail_count = 0;
    int          n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    cabc_core u_cabc_core (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .data_addr(data_addr), .data_wdata(data_wdata),
        .data_we(data_we), .data_rdata(data_rdata), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_ack(irq_ack), .wdg_sel(wdg_sel),
        .core_stopped(core_stopped), .core_waiting(core_waiting),
        .stack_overflow(stack_overflow)
    );

    // combinational memories, presented on the falling edge
    always @(negedge sys_clk) begin
        prog_rdata <= rom[prog_addr];
        data_rdata <= ram[data_addr];
    end
    always @(posedge sys_clk) begin
        if (data_we === 1'b1) begin
            ram[data_addr] <= data_wdata;
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_halt();
        int n;
        n = 0;
        while (!(core_waiting === 1'b1 || core_stopped === 1'b1) && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic restart(input logic wdg);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        wdg_sel = wdg;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        wait_halt();
    endtask

    // flags z=1 c=0 before the interrupt; handler sets z=0 c=1; return must restore
    task automatic test_irq();
        int n;
        foreach (rom[i]) rom[i] = 8'h45;
        rom[0] = 8'h7F;
        rom[1] = 8'h00;
        rom[3] = 8'h24;
        rom[4] = 8'h1B;
        rom[5] = 8'h20;
        rom[12'h100] = 8'h7F;
        rom[12'h101] = 8'h01;
        rom[12'h102] = 8'h25;
        foreach (ram[i]) ram[i] = 8'h00;
        irq_vector = 12'h100;
        restart(1'b0);
        irq_req = 1'b1;
        n = 0;
        while (irq_ack !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        irq_req = 1'b0;
        chk("irq_ack", 8'h01, {7'h00, irq_ack});
        wait_halt();
        chk("flags after return", 8'h00, ram[8'h20]);
        chk("waiting", 8'h01, {7'h00, core_waiting});
    endtask

    // chain of calls six deep fills the stack, seven deep overflows it
    task automatic test_calls();
        for (int depth = 6; depth < 8; depth++) begin
            foreach (rom[i]) rom[i] = 8'h45;
            for (int k = 0; k < depth; k++) begin
                rom[2 * k] = 8'h01;
                rom[2 * k + 1] = 8'(2 * k + 2);
            end
            restart(1'b0);
            chk("stack overflow", {7'h00, depth == 7}, {7'h00, stack_overflow});
            chk("waiting", 8'h01, {7'h00, core_waiting});
        end
    endtask

    task automatic test_stop(input logic wdg);
        foreach (rom[i]) rom[i] = 8'h45;
        rom[0] = 8'h35;
        restart(wdg);
        chk("stopped", {7'h00, ~wdg}, {7'h00, core_stopped});
        chk("waiting", {7'h00, wdg}, {7'h00, core_waiting});
    endtask

    // unhit markers in 20h; bit set/clear on plain ram 21h/22h, bit tests on 21h and on the acc at FFh
    task automatic test_program();
        foreach (rom[i]) rom[i] = 8'h45;
        foreach (code[i]) rom[i] = code[i];
        rom[12'h232] = 8'h9B;
        rom[12'h233] = 8'h22;
        rom[12'h234] = 8'h7F;
        rom[12'h235] = 8'h01;
        rom[12'h236] = 8'h4A;
        foreach (ram[i]) ram[i] = 8'h00;
        ram[8'h21] = 8'h42;
        ram[8'hFF] = 8'h5A;
        restart(1'b0);
        chk("waiting", 8'h01, {7'h00, core_waiting});
        chk("skip markers", 8'h00, ram[8'h20]);
        chk("bit set clear", 8'hC2, ram[8'h21]);
        chk("backward loop", 8'h10, ram[8'h22]);
        chk("acc not on bus", 8'h5A, ram[8'hFF]);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        test_stop(1'b0);
        test_stop(1'b1);
        test_program();
        test_irq();
        test_calls();
        wrap_up();
    end
endmodule
`default_nettype wire
